// *** rtl/pptc_consts.svh ***
// Constants for the portal, translation and configuration front end
`ifndef PPTC_CONSTS_SVH
`define PPTC_CONSTS_SVH
`define PPTC_CTRL_SIZE      64'h0000_0000_0001_0000
`define PPTC_CTRL_BITS      16
`define PPTC_QUEUES         8
`define PPTC_QBITS          3
`define PPTC_PORTALS_PER_Q  4
`define PPTC_PAGE_BITS      12
`define PPTC_PORTAL_BITS    6
`define PPTC_PORTAL_SPAN    (`PPTC_QUEUES * `PPTC_PORTALS_PER_Q * 4096)
`define PPTC_PORTAL_LOG2    $clog2(`PPTC_PORTAL_SPAN)
`define PPTC_A_CTRL         12'h000
`define PPTC_A_STATUS       12'h004
`define PPTC_A_SWERR        12'h008
`define PPTC_A_CBASE_LO     12'h00C
`define PPTC_A_CBASE_HI     12'h010
`define PPTC_A_PBASE_LO     12'h014
`define PPTC_A_PBASE_HI     12'h018
`define PPTC_A_QCFG         12'h01C
`define PPTC_A_TCMAP        12'h020
`define PPTC_A_CAP          12'h024
`define PPTC_B_EN           0
`define PPTC_B_PASID        1
`define PPTC_B_ATS          2
`define PPTC_B_PRS          3
`define PPTC_B_FILL         4
`define PPTC_B_VC           5
`define PPTC_CTRL_W         6
`define PPTC_B_ERR_XLAT     0
`define PPTC_CAP_TOFF       0
`define PPTC_CAP_POFF       1
`define PPTC_QCFG_POFF      8
`define PPTC_QCFG_PASID     16
`define PPTC_QCFG_SHARED    24
`define PPTC_QIDX_LSB       14
`define PPTC_QIDX_MSB       16
`define PPTC_PSEL_LSB       12
`define PPTC_PSEL_MSB       13
`define PPTC_TC_W           3
`define PPTC_ERR_VEC        11'h000
`define PPTC_FILL_ONES      64'hFFFF_FFFF_FFFF_FFFF
`define PPTC_FILL_ZERO      64'h0000_0000_0000_0000
`endif

// *** rtl/pptc_pkg.sv ***
// Types for the portal, translation and configuration front end
package pptc_pkg;
    typedef enum logic [1:0] {ST_DISABLED, ST_ENABLED, ST_HALTED} pptc_state_t;
    typedef struct packed {
        logic        valid;
        logic        wr;
        logic        dmwr;
        logic [63:0] addr;
    } pptc_req_t;
    typedef struct packed {
        logic        valid;
        logic        ctrl_hit;
        logic        portal_hit;
        logic        accept;
        logic        drop;
        logic        retry;
        logic        rd_valid;
        logic [2:0]  queue;
        logic [1:0]  portal;
        logic [63:0] rd_data;
    } pptc_rsp_t;
endpackage

// *** rtl/pptc_top.sv ***
// Aperture decode, portal filter, translation mode and APB registers
//
// The APB slave port and the register offsets are this design's own decisions.
`include "pptc_consts.svh"
// How it works
// - Control aperture has 64-bit base, 64KB decode
// - Each 64-byte portal starts its own page
// - Four portals per queue in portal aperture
// - Aperture size rounded up to power of two
// - Stray portal writes dropped; deferrable ones retried
// - Portal reads return all zero or ones
// - Interrupts only as MSI-X messages
// - Capability change while active halts, logs error
// - All three on: translate, recoverable faults
// - Only translation on: no PASID, unrecoverable faults
// - All off: untranslated, no PASID, no cache
// - PASID only: untranslated, cache unused
// - No page requests; report faults instead
// - Translation and paging without PASID: recoverable
// - Translation off: no page requests, untranslated
// - Shared queues need PASID enabled
// - Honour per-queue translation opt-out
// - Honour per-queue page request opt-out
// - Traffic class mapped to programmed channel
module pptc_top (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst,
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [11:0]             i_paddr,
    input  wire logic [31:0]             i_pwdata,
    output logic      [31:0]             o_prdata,
    output logic                         o_pready,
    output logic                         o_pslverr,
    input  wire pptc_pkg::pptc_req_t     i_req,
    output pptc_pkg::pptc_rsp_t          o_rsp,
    input  wire logic [2:0]              i_tc,
    output logic      [2:0]              o_vc,
    output logic                         o_msix_req,
    output logic      [10:0]             o_msix_vector,
    output logic      [`PPTC_QUEUES-1:0] o_q_translate,
    output logic      [`PPTC_QUEUES-1:0] o_q_pagereq,
    output logic      [`PPTC_QUEUES-1:0] o_q_fault_report,
    output logic      [`PPTC_QUEUES-1:0] o_q_use_pasid,
    output logic      [`PPTC_QUEUES-1:0] o_q_atc_used,
    output logic      [`PPTC_QUEUES-1:0] o_q_shared_ok
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    pptc_pkg::pptc_state_t     state;
    logic [`PPTC_CTRL_W-1:0]   ctrl;
    logic                      sw_err;
    logic [63:0]               ctrl_base;
    logic [63:0]               portal_base;
    logic [31:0]               qcfg;
    logic [23:0]               tc_map;
    logic [1:0]                optout_cap;

    logic                      wr_en;
    logic                      rd_en;
    logic                      addr_ok;
    logic                      xlat_change;
    logic                      halt_evt;
    logic [31:0]               rd_mux;

    // APB strobes: writes land in the access phase, reads are fetched in setup
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_en = i_psel && !i_penable && !i_pwrite;

    // Decode of mapped offsets
    always_comb
    begin
        case (i_paddr)
            `PPTC_A_CTRL,
            `PPTC_A_STATUS,
            `PPTC_A_SWERR,
            `PPTC_A_CBASE_LO,
            `PPTC_A_CBASE_HI,
            `PPTC_A_PBASE_LO,
            `PPTC_A_PBASE_HI,
            `PPTC_A_QCFG,
            `PPTC_A_TCMAP,
            `PPTC_A_CAP:    addr_ok = 1'b1;
            default:        addr_ok = 1'b0;
        endcase
    end

    // Translation enables altered by a control write
    assign xlat_change = wr_en && (i_paddr == `PPTC_A_CTRL)
                      && (i_pwdata[`PPTC_B_PRS:`PPTC_B_PASID]
                          != ctrl[`PPTC_B_PRS:`PPTC_B_PASID]);
    assign halt_evt = xlat_change && (state != pptc_pkg::ST_DISABLED);

    // Zero wait states; unmapped offsets answer with an error
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_ok;

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            ctrl <= '0;
        end
        else if (wr_en && (i_paddr == `PPTC_A_CTRL))
        begin
            ctrl <= i_pwdata[`PPTC_CTRL_W-1:0];
        end
    end

    // Device state machine
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state <= pptc_pkg::ST_DISABLED;
        end
        else
        begin
            case (state)
                pptc_pkg::ST_DISABLED:
                begin
                    if (wr_en && (i_paddr == `PPTC_A_CTRL) && i_pwdata[`PPTC_B_EN])
                    begin
                        state <= pptc_pkg::ST_ENABLED;
                    end
                end
                pptc_pkg::ST_ENABLED:
                begin
                    if (halt_evt)
                    begin
                        state <= pptc_pkg::ST_HALTED;
                    end
                    else if (wr_en && (i_paddr == `PPTC_A_CTRL) && !i_pwdata[`PPTC_B_EN])
                    begin
                        state <= pptc_pkg::ST_DISABLED;
                    end
                end
                pptc_pkg::ST_HALTED:
                begin
                    if (wr_en && (i_paddr == `PPTC_A_CTRL) && !i_pwdata[`PPTC_B_EN])
                    begin
                        state <= pptc_pkg::ST_DISABLED;
                    end
                end
                default:
                begin
                    state <= pptc_pkg::ST_DISABLED;
                end
            endcase
        end
    end

    // Software error flag, write one to clear, set wins
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            sw_err <= 1'b0;
        end
        else if (halt_evt)
        begin
            sw_err <= 1'b1;
        end
        else if (wr_en && (i_paddr == `PPTC_A_SWERR) && i_pwdata[`PPTC_B_ERR_XLAT])
        begin
            sw_err <= 1'b0;
        end
    end

    // Halt is reported by a message, never by a pin
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_msix_req    <= 1'b0;
            o_msix_vector <= `PPTC_ERR_VEC;
        end
        else
        begin
            o_msix_req    <= halt_evt;
            o_msix_vector <= `PPTC_ERR_VEC;
        end
    end

    // ****************************************************************
    // Aperture bases, queue configuration, channel map
    // ****************************************************************
    // Base registers; bits below the aperture size stay zero
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            ctrl_base   <= '0;
            portal_base <= '0;
        end
        else if (wr_en)
        begin
            case (i_paddr)
                `PPTC_A_CBASE_LO: ctrl_base[31:`PPTC_CTRL_BITS] <=
                                      i_pwdata[31:`PPTC_CTRL_BITS];
                `PPTC_A_CBASE_HI: ctrl_base[63:32] <= i_pwdata;
                `PPTC_A_PBASE_LO: portal_base[31:`PPTC_PORTAL_LOG2] <=
                                      i_pwdata[31:`PPTC_PORTAL_LOG2];
                `PPTC_A_PBASE_HI: portal_base[63:32] <= i_pwdata;
                default:          ctrl_base <= ctrl_base;
            endcase
        end
    end

    // Queue configuration and channel map storage
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            qcfg   <= '0;
            tc_map <= '0;
        end
        else if (wr_en && (i_paddr == `PPTC_A_QCFG))
        begin
            qcfg <= i_pwdata;
        end
        else if (wr_en && (i_paddr == `PPTC_A_TCMAP))
        begin
            tc_map <= i_pwdata[23:0];
        end
    end

    // Opt-out capabilities are fixed on
    assign optout_cap = 2'h3;

    // Read data mux
    always_comb
    begin
        rd_mux = '0;
        case (i_paddr)
            `PPTC_A_CTRL:     rd_mux = {26'h0, ctrl};
            `PPTC_A_STATUS:   rd_mux = {30'h0, state};
            `PPTC_A_SWERR:    rd_mux = {31'h0, sw_err};
            `PPTC_A_CBASE_LO: rd_mux = ctrl_base[31:0];
            `PPTC_A_CBASE_HI: rd_mux = ctrl_base[63:32];
            `PPTC_A_PBASE_LO: rd_mux = portal_base[31:0];
            `PPTC_A_PBASE_HI: rd_mux = portal_base[63:32];
            `PPTC_A_QCFG:     rd_mux = qcfg;
            `PPTC_A_TCMAP:    rd_mux = {8'h0, tc_map};
            `PPTC_A_CAP:      rd_mux = {16'h0, 8'(`PPTC_PORTAL_LOG2),
                                        6'h0, optout_cap};
            default:          rd_mux = '0;
        endcase
    end

    // Read data fetched in setup, standing through the access phase only
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_prdata <= '0;
        end
        else if (rd_en)
        begin
            o_prdata <= rd_mux;
        end
        else
        begin
            o_prdata <= '0;
        end
    end

    // ****************************************************************
    // Aperture decode and portal filter
    // ****************************************************************
    logic [63:0]            ctrl_off;
    logic [63:0]            portal_off;
    logic                   ctrl_hit;
    logic                   portal_hit;
    logic                   on_portal;
    logic [`PPTC_QBITS-1:0] q_idx;

    // Offsets of the request into each aperture
    assign ctrl_off   = i_req.addr - ctrl_base;
    assign portal_off = i_req.addr - portal_base;
    assign ctrl_hit   = (i_req.addr >= ctrl_base)
                     && (ctrl_off < `PPTC_CTRL_SIZE);
    assign portal_hit = (i_req.addr >= portal_base)
                     && (portal_off < 64'(1 << `PPTC_PORTAL_LOG2));
    // Portal only in the first 64 bytes of a page
    assign on_portal  = portal_hit
                     && (portal_off[`PPTC_PAGE_BITS-1:`PPTC_PORTAL_BITS] == '0)
                     && (portal_off < 64'(`PPTC_PORTAL_SPAN));
    assign q_idx = portal_off[`PPTC_QIDX_MSB:`PPTC_QIDX_LSB];

    // Registered response to each request
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_rsp <= '0;
        end
        else
        begin
            o_rsp.valid      <= i_req.valid;
            o_rsp.ctrl_hit   <= i_req.valid && ctrl_hit;
            o_rsp.portal_hit <= i_req.valid && portal_hit;
            o_rsp.queue      <= q_idx;
            o_rsp.portal     <= portal_off[`PPTC_PSEL_MSB:`PPTC_PSEL_LSB];
            o_rsp.accept     <= i_req.valid && i_req.wr && on_portal;
            o_rsp.drop       <= i_req.valid && i_req.wr && portal_hit
                             && !on_portal;
            o_rsp.retry      <= i_req.valid && i_req.wr && i_req.dmwr
                             && portal_hit && !on_portal;
            o_rsp.rd_valid   <= i_req.valid && !i_req.wr && portal_hit;
            o_rsp.rd_data    <= ctrl[`PPTC_B_FILL] ? `PPTC_FILL_ONES
                                                   : `PPTC_FILL_ZERO;
        end
    end

    // ****************************************************************
    // Traffic class to channel map
    // ****************************************************************
    // Channel lookup, zero while the capability is absent
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            o_vc <= '0;
        end
        else
        begin
            o_vc <= ctrl[`PPTC_B_VC] ? tc_map[`PPTC_TC_W*i_tc +: `PPTC_TC_W] : 3'h0;
        end
    end

    // ****************************************************************
    // Per-queue translation mode
    // ****************************************************************
    // Device-level enables, live only while the device is enabled
    logic pasid_on;
    logic ats_on;
    logic prs_on;

    assign pasid_on = ctrl[`PPTC_B_PASID] && (state == pptc_pkg::ST_ENABLED);
    assign ats_on   = ctrl[`PPTC_B_ATS] && (state == pptc_pkg::ST_ENABLED);
    assign prs_on   = ctrl[`PPTC_B_PRS] && ats_on;

    // One copy of the mode logic per work queue
    genvar gq;
    generate
        for (gq = 0; gq < `PPTC_QUEUES; gq++)
        begin : g_queue
            logic q_xl;
            logic q_pr;
            // Effective enables after queue opt-outs
            assign q_xl = ats_on
                       && !(optout_cap[`PPTC_CAP_TOFF] && qcfg[gq]);
            assign q_pr = prs_on && q_xl
                       && !(optout_cap[`PPTC_CAP_POFF] && qcfg[`PPTC_QCFG_POFF+gq]);

            // Registered per-queue mode outputs
            always_ff @(posedge i_core_clk)
            begin
                if (i_rst)
                begin
                    o_q_translate[gq]    <= 1'b0;
                    o_q_pagereq[gq]      <= 1'b0;
                    o_q_fault_report[gq] <= 1'b0;
                    o_q_use_pasid[gq]    <= 1'b0;
                    o_q_atc_used[gq]     <= 1'b0;
                    o_q_shared_ok[gq]    <= 1'b0;
                end
                else
                begin
                    o_q_translate[gq]    <= q_xl;
                    o_q_pagereq[gq]      <= q_pr;
                    o_q_fault_report[gq] <= q_xl && !q_pr;
                    o_q_use_pasid[gq]    <= pasid_on && qcfg[`PPTC_QCFG_PASID+gq];
                    o_q_atc_used[gq]     <= q_xl;
                    o_q_shared_ok[gq]    <= pasid_on && qcfg[`PPTC_QCFG_SHARED+gq];
                end
            end
        end
    endgenerate

endmodule // pptc_top

// *** tb/pptc_host_model.sv ***
// Host side model issuing aperture reads and writes
module pptc_host_model (
    input  wire logic                i_core_clk,
    input  wire pptc_pkg::pptc_rsp_t i_rsp,
    output pptc_pkg::pptc_req_t      o_req
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Requests
    // ****
    localparam logic IOMMU_XLAT = 1'b1; // Translation on, so ATS may be enabled
    initial o_req = '0;
    // One whole portal write or read per call; response taken next cycle
    task automatic xfer(input logic wr, dm, input logic [63:0] a, output pptc_pkg::pptc_rsp_t r);
        @(posedge i_core_clk);
        o_req <= '{valid: 1'b1, wr: wr, dmwr: dm, addr: a};
        @(posedge i_core_clk);
        o_req <= '{valid: 1'b0, wr: 1'b0, dmwr: 1'b0, addr: ~a}; // Released address toggles
        #1 r = i_rsp;
    endtask
endmodule // pptc_host_model

// *** tb/pptc_top_chk.sv ***
// Concurrent checks on the front end ports
`include "pptc_consts.svh"
module pptc_top_chk (
    input wire logic                    i_core_clk,
    input wire logic                    i_rst,
    input wire pptc_pkg::pptc_req_t     i_req,
    input wire pptc_pkg::pptc_rsp_t     o_rsp,
    input wire logic                    o_msix_req,
    input wire logic [10:0]             o_msix_vector,
    input wire logic [`PPTC_QUEUES-1:0] o_q_translate,
    input wire logic [`PPTC_QUEUES-1:0] o_q_pagereq,
    input wire logic [`PPTC_QUEUES-1:0] o_q_fault_report,
    input wire logic [`PPTC_QUEUES-1:0] o_q_atc_used
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Assertions
    // ****
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_rsp_next_cycle: assert property (i_req.valid |=> o_rsp.valid)
        else $error("request without response");
    a_retry_is_drop: assert property (o_rsp.retry |-> o_rsp.drop && !o_rsp.accept)
        else $error("retry without drop");
    a_accept_page_start: assert property (o_rsp.accept |-> $past(i_req.addr[11:6]) == 6'h00)
        else $error("accept off the portal");
    a_accept_queue_index: assert property (o_rsp.accept |->
        o_rsp.queue == $past(i_req.addr[16:14]) && o_rsp.portal == $past(i_req.addr[13:12]))
        else $error("wrong queue or portal");
    a_read_fill_value: assert property (o_rsp.rd_valid |->
        o_rsp.rd_data == `PPTC_FILL_ZERO || o_rsp.rd_data == `PPTC_FILL_ONES)
        else $error("portal read data mixed");
    a_msix_single_pulse: assert property (o_msix_req |-> o_msix_vector == 11'h000 ##1 !o_msix_req)
        else $error("message pulse wrong");
    a_pagereq_needs_xlat: assert property ((o_q_pagereq & ~o_q_translate) == '0)
        else $error("page request without translation");
    a_fault_report_excl: assert property (o_q_fault_report == (o_q_translate & ~o_q_pagereq))
        else $error("fault report mismatch");
    a_cache_with_xlat: assert property (o_q_atc_used == o_q_translate)
        else $error("cache use mismatch");
    c_retry: cover property (o_rsp.retry);
    c_accept: cover property (o_rsp.accept);
    c_halt_msg: cover property (o_msix_req);
endmodule // pptc_top_chk

bind pptc_top pptc_top_chk chk_u (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(i_req), .o_rsp(o_rsp),
    .o_msix_req(o_msix_req), .o_msix_vector(o_msix_vector), .o_q_translate(o_q_translate),
    .o_q_pagereq(o_q_pagereq), .o_q_fault_report(o_q_fault_report),
    .o_q_atc_used(o_q_atc_used)
);

// *** tb/pptc_top_tb_top.sv ***
// Self-checking bench for the portal, translation and configuration front end
`include "pptc_consts.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp=%0h got=%0h", nm, e, g); end end
module pptc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // Signals and instances
    // ****
    logic                i_core_clk = 1'b0;
    logic                i_rst      = 1'b1;
    logic                i_psel     = 1'b0;
    logic                i_penable  = 1'b0;
    logic                i_pwrite   = 1'b0;
    logic [11:0]         i_paddr    = 12'h000;
    logic [31:0]         i_pwdata   = 32'h0000_0000;
    logic [2:0]          i_tc       = 3'h0;
    logic [31:0]         o_prdata, rd;
    logic                o_pready, o_pslverr, o_msix_req, err, a, p, s;
    logic [10:0]         o_msix_vector;
    logic [2:0]          o_vc, prev;
    logic [7:0]          o_q_translate, o_q_pagereq, o_q_fault_report;
    logic [7:0]          o_q_use_pasid, o_q_atc_used, o_q_shared_ok;
    pptc_pkg::pptc_req_t i_req;
    pptc_pkg::pptc_rsp_t o_rsp, r;
    int                  n_errors = 0, cmp_count = 0, msix_cnt = 0;
    localparam logic [63:0] PB = 64'h0000_0002_0000_0000;
    localparam logic [63:0] CB = 64'h0000_0001_0000_0000;
    pptc_top dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_req(i_req),
        .o_rsp(o_rsp), .i_tc(i_tc), .o_vc(o_vc), .o_msix_req(o_msix_req),
        .o_msix_vector(o_msix_vector), .o_q_translate(o_q_translate),
        .o_q_pagereq(o_q_pagereq), .o_q_fault_report(o_q_fault_report),
        .o_q_use_pasid(o_q_use_pasid), .o_q_atc_used(o_q_atc_used),
        .o_q_shared_ok(o_q_shared_ok));
    pptc_host_model host_u (.i_core_clk(i_core_clk), .i_rsp(o_rsp), .o_req(i_req));
    always #50 i_core_clk = ~i_core_clk;
    // Count halt messages
    always @(posedge i_core_clk) if (o_msix_req === 1'b1) msix_cnt++;
    // ****
    // Tasks
    // ****
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        @(posedge i_core_clk);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= wr;
        i_paddr   <= ad;
        i_pwdata  <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do @(posedge i_core_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic chkrd(input logic [11:0] ad, input logic [31:0] e, input string nm);
        apb(1'b0, ad, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask
    task automatic chkq(input logic [7:0] t, pr, f, u, sh);
        `CHK("translate", t, o_q_translate)
        `CHK("pagereq", pr, o_q_pagereq)
        `CHK("fault", f, o_q_fault_report)
        `CHK("atc", t, o_q_atc_used)
        `CHK("pasid", u, o_q_use_pasid)
        `CHK("shared", sh, o_q_shared_ok)
    endtask
    task automatic port(input logic wr, dm, input logic [63:0] ad, input logic [5:0] e);
        host_u.xfer(wr, dm, ad, r);
        `CHK("rsp", e, {r.ctrl_hit, r.portal_hit, r.accept, r.drop, r.retry, r.rd_valid})
    endtask
    task automatic settle();
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ****
    // Tests
    // ****
    initial
    begin
        #500000;
        n_errors++;
        summarize();
    end
    initial
    begin
        repeat (3) @(posedge i_core_clk);
        i_rst <= 1'b0;
        chkrd(`PPTC_A_STATUS, 32'h0000_0000, "status");
        chkrd(`PPTC_A_CAP, 32'h0000_1103, "cap");
        apb(1'b0, 12'h100, 32'h0000_0000);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, `PPTC_A_CBASE_HI, 32'h0000_0001);
        apb(1'b1, `PPTC_A_PBASE_LO, 32'hFFFF_FFFF);
        chkrd(`PPTC_A_PBASE_LO, 32'hFFFE_0000, "pbase");
        apb(1'b1, `PPTC_A_PBASE_LO, 32'h0000_0000);
        apb(1'b1, `PPTC_A_PBASE_HI, 32'h0000_0002);
        apb(1'b1, `PPTC_A_QCFG, 32'hFFFF_0000);
        prev = 3'h0;
        for (int m = 0; m < 8; m++)
        begin
            apb(1'b1, `PPTC_A_CTRL, {28'h0, prev, 1'b0});
            apb(1'b1, `PPTC_A_CTRL, {28'h0, m[2:0], 1'b1});
            prev = m[2:0];
            settle();
            {p, a, s} = m[2:0];
            chkq({8{a}}, {8{a & p}}, {8{a & ~p}}, {8{s}}, {8{s}});
        end
        `CHK("no_halt", 0, msix_cnt)
        apb(1'b1, `PPTC_A_QCFG, 32'hFFFF_0201);
        settle();
        chkq(8'hFE, 8'hFC, 8'h02, 8'hFF, 8'hFF);
        port(1'b1, 1'b0, PB + 64'h1_F000, 6'b011000);
        `CHK("queue", 5'h1F, {r.queue, r.portal})
        port(1'b1, 1'b0, PB + 64'h0_0040, 6'b010100);
        port(1'b1, 1'b1, PB + 64'h0_0040, 6'b010110);
        port(1'b1, 1'b0, PB + 64'h2_0000, 6'b000000);
        port(1'b0, 1'b0, PB, 6'b010001);
        `CHK("fill0", `PPTC_FILL_ZERO, r.rd_data)
        port(1'b1, 1'b0, CB + 64'h0_FFFF, 6'b100000);
        port(1'b1, 1'b0, CB + 64'h1_0000, 6'b000000);
        apb(1'b1, `PPTC_A_TCMAP, 32'h0005_3977);
        settle();
        `CHK("vc_off", 3'h0, o_vc)
        apb(1'b1, `PPTC_A_CTRL, 32'h0000_003F);
        port(1'b0, 1'b0, PB + 64'h1_3000, 6'b010001);
        `CHK("fill1", `PPTC_FILL_ONES, r.rd_data)
        for (int t = 0; t < 8; t++)
        begin
            @(posedge i_core_clk);
            i_tc <= t[2:0];
            @(posedge i_core_clk);
            #1 `CHK("vc", ~t[2:0], o_vc)
        end
        apb(1'b1, `PPTC_A_CTRL, 32'h0000_003B);
        settle();
        `CHK("halt_msg", 1, msix_cnt)
        chkrd(`PPTC_A_STATUS, 32'h0000_0002, "halted");
        chkrd(`PPTC_A_SWERR, 32'h0000_0001, "swerr");
        chkq(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        apb(1'b1, `PPTC_A_SWERR, 32'h0000_0001);
        chkrd(`PPTC_A_SWERR, 32'h0000_0000, "swerr_clr");
        apb(1'b1, `PPTC_A_CTRL, 32'h0000_003A);
        chkrd(`PPTC_A_STATUS, 32'h0000_0000, "disabled");
        summarize();
    end
endmodule // pptc_top_tb_top
